// [csib_change_det.sv]
// Change detector over the watched status fields
`include "csib_consts.svh"
module csib_change_det (
   input  wire logic          core_clk,
   input  wire logic          rst_n,
   input  wire logic          ce,
   input  csib_pkg::csib_watch_t watched,
   output csib_pkg::csib_byte_t  events
);
   csib_pkg::csib_watch_t prev;
   csib_pkg::csib_watch_t diff;
   csib_pkg::csib_watch_t next_prev;
   csib_pkg::csib_byte_t  next_events;
   logic                  armed;
   logic                  next_armed;

   ////////////////////////////////////////////////////////////////////////////
   genvar i;
   generate
      for (i = 0; i < $bits(csib_pkg::csib_watch_t); i++) begin : gDiff
         assign diff[i] = watched[i] ^ prev[i];
      end
   endgenerate

   // First sample after reset only arms, so reset itself raises no event
   always_comb begin
      next_prev = watched;
      next_armed = 1'b1;
      next_events = `CSIB_BYTE_ZERO;
      if (armed) begin
         next_events[`CSIB_EVT_THERMISTOR] = |diff[`CSIB_WATCH_THM_HI:`CSIB_WATCH_THM_LO];
         next_events[`CSIB_EVT_CHG_STATE] = |diff[`CSIB_WATCH_CHG_HI:`CSIB_WATCH_CHG_LO];
         next_events[`CSIB_WATCH_SINGLES-1:0] = diff[`CSIB_WATCH_SINGLES-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         prev <= `CSIB_WATCH_ZERO;
         armed <= 1'b0;
         events <= `CSIB_BYTE_ZERO;
      end else if (ce) begin
         prev <= next_prev;
         armed <= next_armed;
         events <= next_events;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   chk_ovp_edge_event: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && armed && (watched[`CSIB_BIT_OVP] != prev[`CSIB_BIT_OVP]))
      |=> events[`CSIB_BIT_OVP])
      else $error("overvoltage transition raised no event");

   chk_state_field_event: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && armed && (watched[`CSIB_WATCH_THM_HI:`CSIB_WATCH_THM_LO]
         != prev[`CSIB_WATCH_THM_HI:`CSIB_WATCH_THM_LO]))
      |=> events[`CSIB_EVT_THERMISTOR])
      else $error("thermistor field change raised no event");

   // Reset values must never look like a transition
   chk_unarmed_no_event: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && !armed) |=> events == `CSIB_BYTE_ZERO)
      else $error("event raised before detector armed");
endmodule

// [csib_charger_status_irq_bank.sv]
// Charger status, regulator thermal status and change flag registers
// How it works
// - Charger status readable at 0x03, bits 5..0
// - Input valid bit mirrors supply presence
// - Regulator thermal status readable at 0x04
// - Thermal-off bits follow each regulator live
// - Eight change flags readable at 0x05
// - Any charger status, thermistor or charge state transition sets its flag
// - Mask bit zero suppresses that flag's interrupt
`include "csib_consts.svh"
module csib_charger_status_irq_bank (
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic             regRead,
   input  wire logic             regWrite,
   input  csib_pkg::csib_byte_t  regAddr,
   input  csib_pkg::csib_byte_t  regWdata,
   input  wire logic             inputCurrentLimited,
   input  wire logic             inputOvervoltageActive,
   input  wire logic             inputSupplyValid,
   input  wire logic             chargerThermalShutdown,
   input  wire logic             chargerThermalRegulation,
   input  wire logic             chargerTimerExpired,
   input  wire logic             buckOneThermalOff,
   input  wire logic             buckTwoThermalOff,
   input  wire logic             linregOneThermalOff,
   input  wire logic             linregTwoThermalOff,
   input  wire logic             linregThreeThermalOff,
   input  wire logic [2:0]       thermistorState,
   input  wire logic [2:0]       chargeState,
   output csib_pkg::csib_byte_t  regRdata,
   output logic                  regRvalid,
   output logic                  eventPending
);
   csib_pkg::csib_byte_t chgStatus;
   csib_pkg::csib_byte_t thermStatus;
   csib_pkg::csib_byte_t flags;
   csib_pkg::csib_byte_t mask;
   csib_pkg::csib_byte_t events;
   csib_pkg::csib_watch_t watched;
   csib_pkg::csib_byte_t next_chgStatus;
   csib_pkg::csib_byte_t next_thermStatus;
   csib_pkg::csib_byte_t next_flags;
   csib_pkg::csib_byte_t next_mask;
   csib_pkg::csib_byte_t next_regRdata;
   logic                 next_regRvalid;
   logic                 next_eventPending;
   logic                 clearFlags;

   ////////////////////////////////////////////////////////////////////////////
   // Detector registers its events alongside the status copy, so flags trail the status copy by a cycle
   assign watched = {thermistorState, chargeState, inputCurrentLimited,
                     inputOvervoltageActive, inputSupplyValid, chargerThermalShutdown,
                     chargerThermalRegulation, chargerTimerExpired};

   csib_change_det uDet (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .watched  (watched),
      .events   (events)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_chgStatus = `CSIB_BYTE_ZERO;
      next_chgStatus[`CSIB_BIT_INPUT_CURRENT_LIMITED] = inputCurrentLimited;
      next_chgStatus[`CSIB_BIT_OVP] = inputOvervoltageActive;
      next_chgStatus[`CSIB_BIT_VALID] = inputSupplyValid;
      next_chgStatus[`CSIB_BIT_TSHDN] = chargerThermalShutdown;
      next_chgStatus[`CSIB_BIT_TREG] = chargerThermalRegulation;
      next_chgStatus[`CSIB_BIT_TIMER] = chargerTimerExpired;
      next_thermStatus = `CSIB_BYTE_ZERO;
      next_thermStatus[`CSIB_BIT_BUCK1:`CSIB_BIT_LINREG3] = {buckOneThermalOff,
         buckTwoThermalOff, linregOneThermalOff, linregTwoThermalOff, linregThreeThermalOff};
      clearFlags = regRead && (regAddr == `CSIB_ADDR_EVT_FLAGS);
      // Set wins over the read clear so no event is lost
      next_flags = (clearFlags ? `CSIB_BYTE_ZERO : flags) | events;
      // Flag and status registers ignore writes
      next_mask = mask;
      if (regWrite && (regAddr == `CSIB_ADDR_EVT_MASK)) begin
         next_mask = regWdata;
      end
      next_regRvalid = regRead;
      next_regRdata = regRdata;
      if (regRead) begin
         case (regAddr)
            `CSIB_ADDR_CHG_STATUS:  next_regRdata = chgStatus;
            `CSIB_ADDR_REG_THERMAL: next_regRdata = thermStatus;
            `CSIB_ADDR_EVT_FLAGS:   next_regRdata = flags;
            `CSIB_ADDR_EVT_MASK:    next_regRdata = mask;
            default:                next_regRdata = `CSIB_BYTE_ZERO;
         endcase
      end
      next_eventPending = |(next_flags & next_mask);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         chgStatus <= `CSIB_BYTE_ZERO;
         thermStatus <= `CSIB_BYTE_ZERO;
         flags <= `CSIB_BYTE_ZERO;
         mask <= `CSIB_MASK_RESET;
         regRdata <= `CSIB_BYTE_ZERO;
         regRvalid <= 1'b0;
         eventPending <= 1'b0;
      end else if (ce) begin
         chgStatus <= next_chgStatus;
         thermStatus <= next_thermStatus;
         flags <= next_flags;
         mask <= next_mask;
         regRdata <= next_regRdata;
         regRvalid <= next_regRvalid;
         eventPending <= next_eventPending;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   chk_chg_status_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && regRead && regAddr == `CSIB_ADDR_CHG_STATUS)
      |=> (regRdata == $past(chgStatus)) && (regRdata[7:6] == 2'h0) && regRvalid)
      else $error("charger status read returned wrong data");

   chk_input_valid_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      ($past(ce) && $past(rst_n))
      |-> chgStatus[`CSIB_BIT_VALID] == $past(inputSupplyValid))
      else $error("input valid bit does not follow supply");

   chk_therm_status_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && regRead && regAddr == `CSIB_ADDR_REG_THERMAL)
      |=> (regRdata == $past(thermStatus)) && (regRdata[7:5] == 3'h0))
      else $error("regulator thermal read returned wrong data");

   chk_buck_thermal_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      ($past(ce) && $past(rst_n))
      |-> thermStatus[`CSIB_BIT_BUCK1] == $past(buckOneThermalOff))
      else $error("buck one thermal bit does not follow");

   chk_flags_read_data: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && clearFlags) |=> regRdata == $past(flags))
      else $error("flag read returned wrong data");

   chk_event_sets_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && events[`CSIB_BIT_OVP]) |=> flags[`CSIB_BIT_OVP])
      else $error("overvoltage event did not set its flag");

   chk_mask_gates_pending: assert property (@(posedge core_clk) disable iff (!rst_n)
      ($past(rst_n)) |-> eventPending == |(flags & mask))
      else $error("pending output disagrees with masked flags");

   chk_read_clears_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && clearFlags && events == `CSIB_BYTE_ZERO) |=> flags == `CSIB_BYTE_ZERO)
      else $error("flag read did not clear flags");

   chk_set_beats_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && clearFlags && events != `CSIB_BYTE_ZERO) |=> flags == $past(events))
      else $error("event lost during flag read");

   chk_event_reaches_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
      ce |=> (flags & $past(events)) == $past(events))
      else $error("detected event missing from flags");

   chk_flags_stay_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && !clearFlags) |=> (flags & $past(flags)) == $past(flags))
      else $error("flag dropped without a flag read");

   chk_flags_write_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && regWrite && !regRead && regAddr == `CSIB_ADDR_EVT_FLAGS
         && events == `CSIB_BYTE_ZERO)
      |=> flags == $past(flags))
      else $error("write altered the flag register");

   chk_mask_write_lands: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && regWrite && regAddr == `CSIB_ADDR_EVT_MASK) |=> mask == $past(regWdata))
      else $error("mask write did not land");

   chk_mask_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && !(regWrite && regAddr == `CSIB_ADDR_EVT_MASK)) |=> mask == $past(mask))
      else $error("mask changed without a mask write");

   chk_pending_on_event: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && !regWrite && (events & mask) != `CSIB_BYTE_ZERO) |=> eventPending)
      else $error("unmasked event raised no pending");

   chk_unmapped_read_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && regRead && !(regAddr inside {`CSIB_ADDR_CHG_STATUS, `CSIB_ADDR_REG_THERMAL,
         `CSIB_ADDR_EVT_FLAGS, `CSIB_ADDR_EVT_MASK}))
      |=> regRdata == `CSIB_BYTE_ZERO)
      else $error("unmapped read returned nonzero data");

   chk_rvalid_after_read: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && regRead) |=> regRvalid)
      else $error("read gave no valid pulse");

   chk_rvalid_idle_low: assert property (@(posedge core_clk) disable iff (!rst_n)
      (ce && !regRead) |=> !regRvalid)
      else $error("valid pulse without a read");

   // Clock enable low must hold every flop, even with strobes present
   chk_freeze_state: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!ce && rst_n) |=> $stable(flags) && $stable(mask) && $stable(regRdata))
      else $error("state moved while clock enable low");

   chk_freeze_outputs: assert property (@(posedge core_clk) disable iff (!rst_n)
      (!ce && rst_n) |=> $stable(regRvalid) && $stable(eventPending))
      else $error("outputs moved while clock enable low");

   chk_chg_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      (chgStatus >> (`CSIB_BIT_INPUT_CURRENT_LIMITED + 1)) == `CSIB_BYTE_ZERO)
      else $error("unused charger status bits not zero");

   chk_therm_reserved_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
      (thermStatus >> (`CSIB_BIT_BUCK1 + 1)) == `CSIB_BYTE_ZERO)
      else $error("unused thermal status bits not zero");

   chk_linreg_thermal_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
      ($past(ce) && $past(rst_n))
      |-> thermStatus[`CSIB_BIT_LINREG3] == $past(linregThreeThermalOff))
      else $error("linear regulator three thermal bit does not follow");
endmodule

// [csib_consts.svh]
// Constants for the charger status and event flag bank
`ifndef CSIB_CONSTS_SVH
`define CSIB_CONSTS_SVH
`define CSIB_ADDR_CHG_STATUS   8'h03
`define CSIB_ADDR_REG_THERMAL  8'h04
`define CSIB_ADDR_EVT_FLAGS    8'h05
`define CSIB_ADDR_EVT_MASK     8'h07
`define CSIB_BYTE_ZERO         8'h00
`define CSIB_MASK_RESET        8'h00
`define CSIB_WATCH_ZERO        12'h000
`define CSIB_BIT_INPUT_CURRENT_LIMITED          5
`define CSIB_BIT_OVP           4
`define CSIB_BIT_VALID         3
`define CSIB_BIT_TSHDN         2
`define CSIB_BIT_TREG          1
`define CSIB_BIT_TIMER         0
`define CSIB_BIT_BUCK1         4
`define CSIB_BIT_LINREG3       0
`define CSIB_EVT_THERMISTOR    7
`define CSIB_EVT_CHG_STATE     6
`define CSIB_WATCH_SINGLES     6
`define CSIB_WATCH_THM_LO      9
`define CSIB_WATCH_THM_HI      11
`define CSIB_WATCH_CHG_LO      6
`define CSIB_WATCH_CHG_HI      8
`endif

// [csib_host_model.sv]
// Host processor model issuing register reads and writes on the strobe port
module csib_host_model (
   input  wire logic            core_clk,
   output logic                 regRead,
   output logic                 regWrite,
   output csib_pkg::csib_byte_t regAddr,
   output csib_pkg::csib_byte_t regWdata
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      regRead = 1'b0;
      regWrite = 1'b0;
      regAddr = 8'h00;
      regWdata = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Strobe held one full cycle; address inverted after release so stale values show
   task automatic rd(input csib_pkg::csib_byte_t addr);
      @(posedge core_clk);
      #1;
      regAddr = addr;
      regRead = 1'b1;
      @(posedge core_clk);
      #1;
      regRead = 1'b0;
      regAddr = ~addr;
   endtask
   task automatic wr(input csib_pkg::csib_byte_t addr, input csib_pkg::csib_byte_t data);
      @(posedge core_clk);
      #1;
      regAddr = addr;
      regWdata = data;
      regWrite = 1'b1;
      @(posedge core_clk);
      #1;
      regWrite = 1'b0;
      regAddr = ~addr;
      regWdata = ~data;
   endtask
endmodule

// [csib_pkg.sv]
// Types shared by the charger status and event flag bank
package csib_pkg;
   typedef logic [7:0]  csib_byte_t;
   typedef logic [11:0] csib_watch_t;
endpackage

// [test_charger_status_irq_bank.sv]
// Self-checking bench for the charger status and event flag bank
module test_charger_status_irq_bank;
   timeunit 1ns;
   timeprecision 100ps;
   logic                 core_clk;
   logic                 rst_n;
   logic                 ce;
   logic                 regRead;
   logic                 regWrite;
   csib_pkg::csib_byte_t regAddr;
   csib_pkg::csib_byte_t regWdata;
   csib_pkg::csib_byte_t regRdata;
   logic                 regRvalid;
   logic                 eventPending;
   logic [5:0]           chg;
   logic [4:0]           thr;
   logic [2:0]           thm;
   logic [2:0]           cst;
   logic [5:0]           nChg;
   logic [2:0]           nThm;
   logic [2:0]           nCst;
   csib_pkg::csib_byte_t flags;
   csib_pkg::csib_byte_t expq[$];
   int                   miscompares;
   int                   samplesChecked;
   initial core_clk = 1'b0;
   always #25 core_clk = ~core_clk;
   csib_host_model u_csib_host_model (.core_clk(core_clk), .regRead(regRead),
      .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata));
   csib_charger_status_irq_bank u_csib_charger_status_irq_bank (.core_clk(core_clk),
      .rst_n(rst_n), .ce(ce), .regRead(regRead), .regWrite(regWrite), .regAddr(regAddr),
      .regWdata(regWdata), .inputCurrentLimited(chg[5]), .inputOvervoltageActive(chg[4]),
      .inputSupplyValid(chg[3]), .chargerThermalShutdown(chg[2]),
      .chargerThermalRegulation(chg[1]), .chargerTimerExpired(chg[0]),
      .buckOneThermalOff(thr[4]), .buckTwoThermalOff(thr[3]), .linregOneThermalOff(thr[2]),
      .linregTwoThermalOff(thr[1]), .linregThreeThermalOff(thr[0]), .thermistorState(thm),
      .chargeState(cst), .regRdata(regRdata), .regRvalid(regRvalid),
      .eventPending(eventPending));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input csib_pkg::csib_byte_t got, input csib_pkg::csib_byte_t want);
      samplesChecked++;
      if (got !== want) begin
         miscompares++;
         $display("mismatch %0t got %h expected %h", $time, got, want);
      end
   endtask
   task automatic rdx(input csib_pkg::csib_byte_t addr, input csib_pkg::csib_byte_t val);
      expq.push_back(val);
      u_csib_host_model.rd(addr);
   endtask
   task automatic close_out;
      if (expq.size() != 0) begin
         miscompares++;
         $display("mismatch %0t expected read answers never came", $time);
      end
      if (miscompares == 0 && samplesChecked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Read data sampled mid-cycle, well clear of the launching edge
   always @(negedge core_clk) begin
      if (regRvalid === 1'b1) begin
         if (expq.size() == 0) begin
            miscompares++;
            $display("mismatch %0t read data with nothing expected", $time);
         end else
            check(regRdata, expq.pop_front());
      end
   end
   initial begin
      #100000;
      miscompares++;
      close_out();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      chg = 6'h00;
      thr = 5'h00;
      thm = 3'h0;
      cst = 3'h0;
      void'($urandom(87));
      repeat (2) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      rdx(8'h03, 8'h00);
      rdx(8'h04, 8'h00);
      rdx(8'h05, 8'h00);
      rdx(8'h07, 8'h00);
      rdx(8'h02, 8'h00);
      for (int i = 0; i < 12; i++) begin
         nChg = 6'($urandom);
         nThm = 3'($urandom);
         nCst = 3'($urandom);
         flags = {nThm != thm, nCst != cst, chg ^ nChg};
         chg = nChg;
         thm = nThm;
         cst = nCst;
         thr = 5'($urandom);
         repeat (3) @(posedge core_clk);
         rdx(8'h03, {2'b00, chg});
         rdx(8'h04, {3'b000, thr});
         rdx(8'h05, flags);
         rdx(8'h05, 8'h00);
      end
      u_csib_host_model.wr(8'h07, 8'h10);
      chg[4] = ~chg[4];
      repeat (3) @(posedge core_clk);
      #1;
      check({7'h00, eventPending}, 8'h01);
      u_csib_host_model.wr(8'h07, 8'h00);
      check({7'h00, eventPending}, 8'h00);
      u_csib_host_model.wr(8'h03, 8'hFF);
      u_csib_host_model.wr(8'h05, 8'hFF);
      rdx(8'h03, {2'b00, chg});
      rdx(8'h05, 8'h10);
      // Flag lands on the very edge that takes the read, so it must survive the clear
      chg[0] = ~chg[0];
      rdx(8'h05, 8'h00);
      rdx(8'h05, 8'h01);
      // Change made while clock enable is low is seen only once it rises
      @(posedge core_clk);
      #1;
      ce = 1'b0;
      chg[2] = ~chg[2];
      repeat (3) @(posedge core_clk);
      #1;
      ce = 1'b1;
      rdx(8'h05, 8'h00);
      rdx(8'h05, 8'h04);
      // Mid-run reset clears the mask and raises no event from live inputs
      u_csib_host_model.wr(8'h07, 8'hFF);
      rst_n = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      rdx(8'h05, 8'h00);
      rdx(8'h07, 8'h00);
      rdx(8'h03, {2'b00, chg});
      repeat (2) @(posedge core_clk);
      close_out();
   end
endmodule
